// [rtl/timer1_top.sv]
// Function
// - Counter advances only while count_on is set; clearing it stops counting.
// - Power-on reset stops counter, control reads zero; other resets keep count/control.
// - Sixteen-bit count; rollover from ffff to 0000 latches overflow_flag.
// - Interrupt request only with overflow_irq_enable; flag latched regardless.
// - Prescale field divides input: 1, 2, 4 or 8.
// - source_select 0 counts instruction clock, 1 counts external rising edges.
// - ext_sync_bypass picks synced or unsynced external counting; ignored internally.
// - Oscillator enable forces both oscillator pins to inputs.
// - Low-power oscillator keeps running during sleep.
// - Without wide access, both count bytes are read and written directly.
// - With wide access, low-byte read copies live high byte into buffer.
// - With wide access, high write loads buffer; low write moves it live.
// - Low-byte write clears prescaler; high-byte write leaves it alone.
// - Compare mode 1011 trigger clears counter and starts enabled conversion.
// - Trigger clear never sets overflow_flag.
// - Software count write in the trigger cycle wins over the clear.
// - In compare mode 1011, compare value pair acts as period: counter clears to zero on match.
`timescale 1ns/1ps
`default_nettype none
`include "timer1_params.svh"

module timer1_top #(
  parameter int INSTR_DIV = `INSTR_CLOCK_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic other_reset,
  input wire logic sleep,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_count_pin,
  input wire logic osc_in_dir,
  input wire logic osc_out_dir,
  input wire logic [3:0] compare_mode_field,
  input wire timer1_pkg::count_t compare_value_pair,
  input wire logic adc_enable,
  output logic adc_start,
  output logic overflow_irq,
  output logic osc_run,
  output logic osc_in_oe_n,
  output logic osc_out_oe_n
);
  import timer1_pkg::*;

  if (INSTR_DIV != 4) begin : g_div_check
    $error("INSTR_DIV must be 4: divider is two bits wide");
  end

  timer_state_t s;
  timer_state_t next_s;
  logic [1:0] rst_sync;
  logic rst_int_n;
  logic ext_sync_rise;
  logic ext_raw_rise;

  // Release the asynchronous reset cleanly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  edge_sync u_edge_sync (
    .clk(clk),
    .rst_n(rst_int_n),
    .pin(ext_count_pin),
    .sync_rise(ext_sync_rise),
    .raw_rise(ext_raw_rise)
  );

  function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: prescale_limit = 3'h0;
      2'h1: prescale_limit = 3'h1;
      2'h2: prescale_limit = 3'h3;
      2'h3: prescale_limit = 3'h7;
    endcase
  endfunction

  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    reg_index = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
  endfunction

  logic accept;
  logic rd_accept;
  logic wide;
  logic on;
  logic ext_src;
  logic source_event;
  logic tick;
  logic trigger;
  logic count_written;
  logic overflow;
  logic [2:0] rd_index;
  byte_t wbyte;

  always_comb begin
    next_s = s;
    next_s.adc_start = 1'b0;
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
    wide = s.control[`CTL_WIDE_ACCESS];
    on = s.control[`CTL_COUNT_ON];
    ext_src = s.control[`CTL_SOURCE_SEL];
    wbyte = hwdata[7:0];
    count_written = 1'b0;
    overflow = 1'b0;

    // Instruction clock enable; halted in sleep
    next_s.instr_div = s.instr_div + 2'h1;

    // Unsynced edges still reach the counter in sleep; synced ones need the clock
    if (ext_src) begin
      if (s.control[`CTL_SYNC_BYPASS]) begin
        source_event = ext_raw_rise;
      end else begin
        source_event = ext_sync_rise & ~sleep;
      end
    end else begin
      source_event = (s.instr_div == 2'h3) & ~sleep;
    end

    // Prescaler only runs while enabled
    tick = 1'b0;
    if (on && source_event) begin
      if (s.prescale == prescale_limit(s.control[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB])) begin
        next_s.prescale = 3'h0;
        tick = 1'b1;
      end else begin
        next_s.prescale = s.prescale + 3'h1;
      end
    end

    // Compare match acts as period register
    trigger = (compare_mode_field == `COMPARE_MODE_TRIGGER) &&
              (s.count == compare_value_pair);

    if (trigger) begin
      next_s.count = 16'h0000;
      next_s.adc_start = adc_enable;
    end else if (tick) begin
      next_s.count = s.count + 16'h0001;
      overflow = (s.count == 16'hffff);
    end
    // Trigger path leaves overflow low by construction

    // Data phase of a write
    if (s.wr_pending) begin
      unique case (s.wr_index)
        `OFS_CONTROL: begin
          next_s.control = wbyte & `CTL_WRITE_MASK;
        end
        `OFS_COUNT_LOW: begin
          count_written = 1'b1;
          next_s.prescale = 3'h0;
          if (wide) begin
            next_s.count = {s.high_buffer, wbyte};
          end else begin
            next_s.count = {s.count[15:8], wbyte};
          end
        end
        `OFS_COUNT_HIGH: begin
          // Prescaler intentionally untouched here
          if (wide) begin
            next_s.high_buffer = wbyte;
          end else begin
            count_written = 1'b1;
            // Low byte must survive a same-cycle trigger clear
            next_s.count = {wbyte, trigger ? s.count[7:0] : next_s.count[7:0]};
          end
        end
        `OFS_STATUS: begin
          if (wbyte[`STS_OVERFLOW_FLAG]) begin
            next_s.overflow_flag = 1'b0;
          end
          next_s.overflow_irq_enable = wbyte[`STS_OVERFLOW_IRQ_EN];
        end
        default: begin
        end
      endcase
    end

    // Written value wins; the clear from trigger is discarded
    if (count_written && trigger) begin
      next_s.adc_start = next_s.adc_start;
    end

    // Set wins over a same-cycle software clear
    if (overflow && !count_written) begin
      next_s.overflow_flag = 1'b1;
    end

    // Address phase
    accept = hsel & hready & htrans[1];
    rd_accept = accept & ~hwrite;
    rd_index = reg_index(haddr);
    next_s.wr_pending = accept & hwrite;
    next_s.wr_index = rd_index;
    if (rd_accept) begin
      unique case (rd_index)
        `OFS_CONTROL: next_s.hrdata = {24'h0, s.control};
        `OFS_COUNT_LOW: begin
          next_s.hrdata = {24'h0, s.count[7:0]};
          if (wide) begin
            next_s.high_buffer = s.count[15:8];
          end
        end
        `OFS_COUNT_HIGH: begin
          if (wide) begin
            next_s.hrdata = {24'h0, s.high_buffer};
          end else begin
            next_s.hrdata = {24'h0, s.count[15:8]};
          end
        end
        `OFS_STATUS: begin
          next_s.hrdata = {30'h0, s.overflow_irq_enable, s.overflow_flag};
        end
        default: next_s.hrdata = 32'h0;
      endcase
    end

    // Non-power-on reset clears flags and prescaler, keeps count and control
    if (other_reset) begin
      next_s.overflow_flag = 1'b0;
      next_s.overflow_irq_enable = 1'b0;
      next_s.prescale = 3'h0;
    end

    next_s.overflow_irq = next_s.overflow_flag & next_s.overflow_irq_enable;
    // Oscillator enable ignores sleep so time keeps advancing
    next_s.osc_run = next_s.control[`CTL_OSC_ENABLE];
    if (next_s.control[`CTL_OSC_ENABLE]) begin
      next_s.osc_in_oe_n = 1'b1;
      next_s.osc_out_oe_n = 1'b1;
    end else begin
      next_s.osc_in_oe_n = osc_in_dir;
      next_s.osc_out_oe_n = osc_out_dir;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s <= '0;
      s.control <= `CTL_RESET;
      s.hreadyout <= 1'b1;
      s.osc_in_oe_n <= 1'b1;
      s.osc_out_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign adc_start = s.adc_start;
  assign overflow_irq = s.overflow_irq;
  assign osc_run = s.osc_run;
  assign osc_in_oe_n = s.osc_in_oe_n;
  assign osc_out_oe_n = s.osc_out_oe_n;

  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:8], haddr[31:5], haddr[1:0]};

endmodule

`default_nettype wire

// [rtl/timer1_params.svh]
`ifndef TIMER1_PARAMS_SVH
`define TIMER1_PARAMS_SVH

// Register word indices, decoded from haddr[4:2]
`define OFS_CONTROL 3'h0
`define OFS_COUNT_LOW 3'h1
`define OFS_COUNT_HIGH 3'h2
`define OFS_STATUS 3'h3
`define ADDR_IDX_LSB 2
`define ADDR_IDX_MSB 4

// Control register fields
`define CTL_COUNT_ON 0
`define CTL_SOURCE_SEL 1
`define CTL_SYNC_BYPASS 2
`define CTL_OSC_ENABLE 3
`define CTL_PRESCALE_LSB 4
`define CTL_PRESCALE_MSB 5
`define CTL_WIDE_ACCESS 7
`define CTL_WRITE_MASK 8'hbf
`define CTL_RESET 8'h00

// Status register fields
`define STS_OVERFLOW_FLAG 0
`define STS_OVERFLOW_IRQ_EN 1

// Compare unit mode that clears the counter
`define COMPARE_MODE_TRIGGER 4'hb

// Instruction clock is the system clock divided by this count
`define INSTR_CLOCK_DIV 4

`endif

// [rtl/timer1_pkg.sv]
package timer1_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [15:0] count_t;

  typedef struct packed {
    logic sync_stage1;
    logic sync_stage2;
    logic level_prev;
  } edge_state_t;

  typedef struct packed {
    logic [1:0] instr_div;
    logic [2:0] prescale;
    count_t count;
    byte_t high_buffer;
    byte_t control;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic wr_pending;
    logic [2:0] wr_index;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic overflow_irq;
    logic adc_start;
    logic osc_run;
    logic osc_in_oe_n;
    logic osc_out_oe_n;
  } timer_state_t;

endpackage

// [rtl/edge_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic sync_rise,
  output logic raw_rise
);
  import timer1_pkg::*;

  edge_state_t s;
  edge_state_t next_s;
  logic raw_prev;

  // Stage one feeds stage two only
  always_comb begin
    next_s = s;
    next_s.sync_stage1 = pin;
    next_s.sync_stage2 = s.sync_stage1;
    next_s.level_prev = s.sync_stage2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      raw_prev <= 1'b0;
    end else begin
      s <= next_s;
      raw_prev <= pin;
    end
  end

  assign sync_rise = s.sync_stage2 & ~s.level_prev;
  // Unsynchronised path: two flops less latency, no metastability guard
  assign raw_rise = pin & ~raw_prev;

endmodule

`default_nettype wire

// [test/timer1_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "timer1_params.svh"
module timer1_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic osc_in_dir,
  input wire logic [3:0] compare_mode_field,
  input wire logic adc_enable,
  input wire logic adc_start,
  input wire logic osc_run,
  input wire logic osc_in_oe_n,
  input wire logic osc_out_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_req;
    hsel && htrans[1] && !hwrite;
  endsequence
  sequence ctl_rd;
    rd_req ##0 haddr[4:2] == 3'h0;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  byte_wide_a: assert property (rd_req |=> hrdata[31:8] == 24'h0)
    else $error("read data above byte");
  ctl_gap_a: assert property (ctl_rd |=> !hrdata[6])
    else $error("control bit 6 set");
  osc_input_a: assert property (osc_run |-> osc_in_oe_n && osc_out_oe_n)
    else $error("oscillator pin driven");
  dir_pass_a: assert property (!osc_run |-> osc_in_oe_n == $past(osc_in_dir))
    else $error("direction not passed");
  sleep_osc_a: assert property (sleep && $past(sleep) |-> $stable(osc_run))
    else $error("oscillator changed in sleep");
  adc_cause_a: assert property (adc_start |-> $past(adc_enable) &&
    $past(compare_mode_field) == `COMPARE_MODE_TRIGGER) else $error("stray conversion start");
  adc_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start too long");
endmodule
bind timer1_top timer1_props timer1_props_inst (.clk, .rst_n, .sleep, .hsel, .haddr, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .osc_in_dir, .compare_mode_field, .adc_enable,
  .adc_start, .osc_run, .osc_in_oe_n, .osc_out_oe_n);
`default_nettype wire

// [test/ext_clk_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ext_clk_model #(
  parameter int HALF_NS = 130
) (
  input wire logic run,
  output logic pin
);
  initial pin = 1'h0;
  // Free of clk and sleep; with HALF_NS 130 every fifth toggle lands on a clk rising edge
  always begin
    wait (run);
    #HALF_NS pin = ~pin;
  end
endmodule
`default_nettype wire

// [test/sixteen_bit_timer_counter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "timer1_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module sixteen_bit_timer_counter_tb;
  import timer1_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, other_reset = 1'h0, sleep = 1'h0, hsel = 1'h0;
  logic hwrite = 1'h0, run = 1'h0, osc_in_dir = 1'h1, osc_out_dir = 1'h1, adc_enable = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0] compare_mode_field = 4'h0;
  count_t compare_value_pair = 16'h0, cnt;
  logic hreadyout, hresp, ext_count_pin, adc_start, overflow_irq, osc_run;
  logic osc_in_oe_n, osc_out_oe_n;
  byte_t b;
  int n_errors = 0, tests_run = 0, edges = 0, pulses = 0, n, p;
  timer1_top timer1_top_inst (.clk, .rst_n, .other_reset, .sleep, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_count_pin, .osc_in_dir, .osc_out_dir, .compare_mode_field, .compare_value_pair,
    .adc_enable, .adc_start, .overflow_irq, .osc_run, .osc_in_oe_n, .osc_out_oe_n);
  ext_clk_model ext_clk_model_inst (.run, .pin(ext_count_pin));
  always #25 clk = ~clk;
  always @(posedge ext_count_pin) edges++;
  always @(posedge clk) if (adc_start === 1'h1) pulses++;
  // Instruction-clock phase is not cleared by a write, hence the slack of one
  function automatic logic near(count_t a, int e);
    return a + 1 >= e && a <= e + 1;
  endfunction
  function automatic int ticks(int cyc, int ps);
    return cyc / (`INSTR_CLOCK_DIV << ps);
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    b = hrdata[7:0];
  endtask
  task automatic get_cnt;
    bus(1'h0, 8'h4, 32'h0);
    cnt[7:0] = b;
    bus(1'h0, 8'h8, 32'h0);
    cnt[15:8] = b;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h01d4));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    bus(1'h0, 8'h0, 32'h0);
    `CHK(b, `CTL_RESET)
    get_cnt;
    `CHK(cnt, 16'h0)
    for (p = 0; p < 4; p++) begin
      n = 100 + $urandom % 100;
      bus(1'h1, 8'h4, 32'h0);
      bus(1'h1, 8'h0, 32'(p * 16 + 1));
      repeat (n) @(posedge clk);
      bus(1'h1, 8'h0, 32'h0);
      get_cnt;
      `CHK(near(cnt, ticks(n + 3, p)), 1'h1)
    end
    n = cnt;
    repeat (50) @(posedge clk);
    get_cnt;
    `CHK(cnt, count_t'(n))
    bus(1'h1, 8'h8, 32'hff);
    bus(1'h1, 8'h4, 32'hfc);
    bus(1'h1, 8'h0, 32'h1);
    repeat (40) @(posedge clk);
    bus(1'h1, 8'h0, 32'h0);
    bus(1'h0, 8'hc, 32'h0);
    `CHK(b[1:0], 2'h1)
    `CHK(overflow_irq, 1'h0)
    bus(1'h1, 8'hc, 32'h2);
    repeat (2) @(negedge clk);
    `CHK(overflow_irq, 1'h1)
    bus(1'h1, 8'hc, 32'h3);
    repeat (2) @(negedge clk);
    `CHK(overflow_irq, 1'h0)
    bus(1'h1, 8'h0, 32'h8);
    sleep <= 1'h1;
    osc_in_dir <= 1'h0;
    // Oscillator enabled but never used as count source; count_on stays clear
    repeat (3) @(negedge clk);
    `CHK({osc_run, osc_in_oe_n, osc_out_oe_n}, 3'h7)
    @(posedge clk);
    sleep <= 1'h0;
    bus(1'h1, 8'h0, 32'h0);
    repeat (2) @(negedge clk);
    `CHK({osc_in_oe_n, osc_out_oe_n}, 2'h1)
    bus(1'h1, 8'h0, 32'h80);
    bus(1'h1, 8'h8, 32'h12);
    bus(1'h1, 8'h4, 32'h0);
    bus(1'h1, 8'h0, 32'h81);
    bus(1'h0, 8'h4, 32'h0);
    repeat (1400) @(posedge clk);
    bus(1'h0, 8'h8, 32'h0);
    `CHK(b, 8'h12)
    bus(1'h1, 8'h0, 32'h80);
    bus(1'h1, 8'h8, 32'h56);
    bus(1'h1, 8'h0, 32'h30);
    get_cnt;
    `CHK(cnt[15:8], 8'h13)
    bus(1'h1, 8'h0, 32'hb0);
    bus(1'h1, 8'h8, 32'h56);
    bus(1'h1, 8'h4, 32'h78);
    other_reset <= 1'h1;
    @(posedge clk);
    other_reset <= 1'h0;
    bus(1'h0, 8'h0, 32'h0);
    `CHK(b, 8'hb0)
    bus(1'h1, 8'h0, 32'h0);
    get_cnt;
    `CHK(cnt, 16'h5678)
    // Trigger clearing with the instruction-clock source, even with counting stopped
    compare_mode_field <= `COMPARE_MODE_TRIGGER;
    bus(1'h1, 8'h8, 32'h0);
    bus(1'h1, 8'h4, 32'h0);
    bus(1'h1, 8'h4, 32'h55);
    get_cnt;
    `CHK(cnt, 16'h55)
    compare_value_pair <= 16'h55;
    get_cnt;
    `CHK(cnt, 16'h0)
    compare_value_pair <= 16'h10 + 16'($urandom % 16);
    adc_enable <= 1'h1;
    bus(1'h1, 8'hc, 32'h1);
    pulses = 0;
    bus(1'h1, 8'h0, 32'h1);
    repeat (3000) @(posedge clk);
    bus(1'h1, 8'h0, 32'h0);
    get_cnt;
    `CHK(cnt <= compare_value_pair, 1'h1)
    `CHK(near(count_t'(pulses), 3000 / (4 * compare_value_pair)), 1'h1)
    bus(1'h0, 8'hc, 32'h0);
    `CHK(b[0], 1'h0)
    compare_mode_field <= 4'h0;
    adc_enable <= 1'h0;
    for (n = 0; n < 2; n++) begin
      p = $urandom % 4;
      bus(1'h1, 8'h4, 32'h0);
      bus(1'h1, 8'h0, 32'(p * 16 + n * 4 + 3));
      edges = 0;
      run <= 1'h1;
      repeat (400) @(posedge clk);
      run <= 1'h0;
      repeat (20) @(posedge clk);
      bus(1'h1, 8'h0, 32'h0);
      get_cnt;
      `CHK(cnt, count_t'(edges >> p))
    end
    wrap_up;
  end
endmodule
`default_nettype wire
